//--- rtl/dsl_top.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Disable-password compares selected password; match leaves locked state.
// - Disable-password never alters the stored master password.
// - Master password becomes usable again only once a user password is set.
// - Control bit 0 selects user or master; 32-byte password follows.
// - Erase-unit aborts on password mismatch.
// - Erase-unit control bit 1 picks normal or enhanced erase.
// - Freeze-lock enters frozen state; lock-changing commands then abort.
// - Frozen device aborts set, unlock, disable, erase-prepare, erase-unit.
// - Frozen state clears only on power-off or hardware reset.
// - Freeze-lock while frozen completes and device stays frozen.
// - Set-password bit 0 picks user or master, bit 8 high or maximum.
// - Revision code in word 17 valid only when identifier bit is one.
// - User password at high level: store, lock from next reset, both unlock.
// - User password at maximum level: store, lock from next reset, user only.
// - Master set stores password and revision, lock and level unchanged.
// - Master unlock compares at high level, rejected outright at maximum.
// - User unlock compares supplied password with stored user password.
// - Locked unlock mismatch aborts and decrements counter starting at five.
// - Counter at zero aborts unlock and erase-unit until reset.
// - Unlock while unlocked leaves the counter unchanged.
module dsl_top
  import dsl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_rst_n,
  output logic             erase_start,
  output logic             erase_enhanced
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]             hwr_sync_q;
  logic                   hw_rst_act;
  logic                   pready_q;
  logic                   pslverr_q;
  logic [31:0]            prdata_q;
  logic [15:0]            ctrl_q;
  logic [15:0]            rev_q;
  logic [15:0]            mrev_q;
  logic [`DSL_PW_BITS-1:0] pw_buf_q;
  logic [`DSL_PW_BITS-1:0] user_pw_q;
  logic [`DSL_PW_BITS-1:0] master_pw_q;
  dsl_state_t             st_q;
  logic [7:0]             last_cmd_q;
  dsl_res_t               res_q;
  logic                   erase_q;
  logic                   erase_enh_q;
  logic                   wr_acc;
  logic                   go;
  logic [7:0]             cmd;
  logic                   sel_master;
  logic                   hit;
  logic                   fz_block;

  function automatic logic ofs_mapped(input logic [7:0] a);
    ofs_mapped = (a == `DSL_OFS_CMD) || (a == `DSL_OFS_CTRL) || (a == `DSL_OFS_REV) ||
                 (a == `DSL_OFS_STAT) || (a == `DSL_OFS_MREV) ||
                 ((a >= `DSL_OFS_PW_BASE) && (a <= `DSL_OFS_PW_LAST) && (a[1:0] == 2'b00));
  endfunction

  function automatic logic is_lock_cmd(input logic [7:0] c);
    is_lock_cmd = (c == `DSL_CMD_SET_PW) || (c == `DSL_CMD_UNLOCK) ||
                  (c == `DSL_CMD_DIS_PW) || (c == `DSL_CMD_ER_PREP) ||
                  (c == `DSL_CMD_ER_UNIT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The hardware reset pin is asynchronous to pclk, so it is synchronised.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hwr_sync_q <= 2'b11;
    end
    else
    begin
      hwr_sync_q <= {hwr_sync_q[0], hw_rst_n};
    end
  end
  assign hw_rst_act = !hwr_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: every transfer completes with one wait-free access phase.
  assign wr_acc = psel && penable && pready_q && pwrite;
  assign go     = wr_acc && (paddr == `DSL_OFS_CMD) && !hw_rst_act;
  assign cmd    = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && !ofs_mapped(paddr);
      prdata_q  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `DSL_OFS_CMD:  prdata_q <= {22'h0, res_q, last_cmd_q};
          `DSL_OFS_CTRL: prdata_q <= {16'h0000, ctrl_q};
          `DSL_OFS_REV:  prdata_q <= {16'h0000, rev_q};
          `DSL_OFS_STAT: prdata_q <= {23'h0, st_q};
          `DSL_OFS_MREV: prdata_q <= {16'h0000, mrev_q};
          default:       prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Data block staging; the password words are write-only so they never leak.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= 16'h0000;
      rev_q    <= 16'h0000;
      pw_buf_q <= '0;
    end
    else if (wr_acc)
    begin
      if (paddr == `DSL_OFS_CTRL)
      begin
        ctrl_q <= pwdata[15:0];
      end
      if (paddr == `DSL_OFS_REV)
      begin
        rev_q <= pwdata[15:0];
      end
      if (ofs_mapped(paddr) && (paddr >= `DSL_OFS_PW_BASE))
      begin
        pw_buf_q[paddr[4:2]*32 +: 32] <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sel_master = ctrl_q[`DSL_CW_IDENT];
  // Master compare needs high level and an active master password.
  assign hit = sel_master ?
               (st_q.master_act && !st_q.level_max && (pw_buf_q == master_pw_q)) :
               (pw_buf_q == user_pw_q);
  assign fz_block = st_q.frozen && is_lock_cmd(cmd);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_pw_q   <= '0;
      master_pw_q <= '0;
      mrev_q      <= 16'h0000;
    end
    else if (go && !fz_block && (cmd == `DSL_CMD_SET_PW))
    begin
      if (ctrl_q[`DSL_CW_IDENT])
      begin
        master_pw_q <= pw_buf_q;
        mrev_q      <= rev_q;
      end
      else
      begin
        user_pw_q <= pw_buf_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security state and command outcome.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= '{locked: 1'b0, frozen: 1'b0, enabled: 1'b0, level_max: 1'b0,
                      master_act: 1'b0, prep: 1'b0, tries: `DSL_TRY_INIT};
      last_cmd_q <= 8'h00;
      res_q      <= DSL_RES_NONE;
    end
    else if (hw_rst_act)
    begin
      st_q.frozen <= 1'b0;
      st_q.tries  <= `DSL_TRY_INIT;
      st_q.locked <= st_q.enabled;
      st_q.prep   <= 1'b0;
    end
    else if (go)
    begin
      last_cmd_q <= cmd;
      res_q      <= DSL_RES_ABORT;
      st_q.prep  <= 1'b0;
      if (fz_block)
      begin
        res_q <= DSL_RES_ABORT;
      end
      else
      begin
        case (cmd)
          `DSL_CMD_FREEZE:
          begin
            st_q.frozen <= 1'b1;
            res_q       <= DSL_RES_DONE;
          end
          `DSL_CMD_SET_PW:
          begin
            res_q <= DSL_RES_DONE;
            if (!ctrl_q[`DSL_CW_IDENT])
            begin
              st_q.enabled    <= 1'b1;
              st_q.master_act <= 1'b1;
              st_q.level_max  <= ctrl_q[`DSL_CW_LEVEL];
            end
          end
          `DSL_CMD_UNLOCK:
          begin
            if (st_q.tries == '0)
            begin
              res_q <= DSL_RES_ABORT;
            end
            else if (hit)
            begin
              st_q.locked <= 1'b0;
              res_q       <= DSL_RES_DONE;
            end
            else if (st_q.locked)
            begin
              // Outright rejection at maximum level is not counted as a try.
              if (!(sel_master && st_q.level_max))
              begin
                st_q.tries <= st_q.tries - 1'b1;
              end
            end
          end
          `DSL_CMD_DIS_PW:
          begin
            if (hit)
            begin
              st_q.locked     <= 1'b0;
              st_q.enabled    <= 1'b0;
              st_q.master_act <= 1'b0;
              st_q.level_max  <= 1'b0;
              res_q           <= DSL_RES_DONE;
            end
          end
          `DSL_CMD_ER_PREP:
          begin
            st_q.prep <= 1'b1;
            res_q     <= DSL_RES_DONE;
          end
          `DSL_CMD_ER_UNIT:
          begin
            // Without a directly preceding prepare the erase is refused.
            if (st_q.prep && (st_q.tries != '0) && hit)
            begin
              st_q.locked     <= 1'b0;
              st_q.enabled    <= 1'b0;
              st_q.master_act <= 1'b0;
              st_q.level_max  <= 1'b0;
              res_q           <= DSL_RES_DONE;
            end
          end
          default:
          begin
            res_q <= DSL_RES_ABORT;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase request towards the media engine: one-cycle pulse plus mode level.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_q     <= 1'b0;
      erase_enh_q <= 1'b0;
    end
    else
    begin
      erase_q <= go && !fz_block && (cmd == `DSL_CMD_ER_UNIT) && st_q.prep &&
                 (st_q.tries != '0) && hit;
      if (go && !fz_block && (cmd == `DSL_CMD_ER_UNIT))
      begin
        erase_enh_q <= ctrl_q[`DSL_CW_ERMODE];
      end
    end
  end
  assign erase_start    = erase_q;
  assign erase_enhanced = erase_enh_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  frozen_abort_a: assert property (go && st_q.frozen && is_lock_cmd(cmd)
    |=> res_q == DSL_RES_ABORT && st_q.frozen)
    else $error("Frozen device completed a lock command.");
  freeze_stay_a: assert property (go && cmd == `DSL_CMD_FREEZE
    |=> st_q.frozen && res_q == DSL_RES_DONE)
    else $error("Freeze did not complete into frozen state.");
  frozen_hold_a: assert property (st_q.frozen && !hw_rst_act |=> st_q.frozen)
    else $error("Frozen state cleared without reset.");
  hw_reload_a: assert property (hw_rst_act
    |=> st_q.tries == `DSL_TRY_INIT && !st_q.frozen)
    else $error("Hardware reset did not reload counter.");
  zero_abort_a: assert property (go && st_q.tries == '0
    && (cmd == `DSL_CMD_UNLOCK || cmd == `DSL_CMD_ER_UNIT) |=> res_q == DSL_RES_ABORT)
    else $error("Unlock or erase accepted with no tries left.");
  try_dec_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_UNLOCK
    && st_q.locked && !hit && !sel_master && st_q.tries != '0
    |=> st_q.tries == $past(st_q.tries) - 3'h1 && res_q == DSL_RES_ABORT)
    else $error("Mismatch did not decrement the counter.");
  try_keep_a: assert property (go && cmd == `DSL_CMD_UNLOCK && !st_q.locked
    |=> $stable(st_q.tries))
    else $error("Unlock while unlocked changed the counter.");
  master_max_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_UNLOCK
    && sel_master && st_q.level_max |=> res_q == DSL_RES_ABORT)
    else $error("Master unlock accepted at maximum level.");
  dis_master_a: assert property (go && cmd == `DSL_CMD_DIS_PW |=> $stable(master_pw_q))
    else $error("Disable altered the master password.");
  erase_prep_a: assert property (erase_q |-> $past(st_q.prep) && $past(hit))
    else $error("Erase started without prepare and match.");
  master_set_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_SET_PW
    && sel_master |=> $stable(st_q.locked) && $stable(st_q.level_max)
    && mrev_q == $past(rev_q))
    else $error("Master set changed lock or level.");
  dis_unlock_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_DIS_PW && hit
    |=> !st_q.locked && res_q == DSL_RES_DONE)
    else $error("Disable with a matching password kept the lock.");
  dis_miss_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_DIS_PW && !hit
    |=> res_q == DSL_RES_ABORT && $stable(st_q.locked))
    else $error("Disable with a wrong password was accepted.");
  master_react_a: assert property ($rose(st_q.master_act)
    |-> $past(go) && $past(cmd) == `DSL_CMD_SET_PW && !$past(sel_master))
    else $error("Master password reactivated without a user set.");
  user_arm_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_SET_PW
    && !sel_master |=> $stable(st_q.locked) && st_q.enabled)
    else $error("User set changed the lock at once or left locking unarmed.");
  relock_a: assert property (hw_rst_act |=> st_q.locked == $past(st_q.enabled))
    else $error("Hardware reset did not arm the lock from the password state.");
  level_set_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_SET_PW
    && !sel_master |=> st_q.level_max == $past(ctrl_q[`DSL_CW_LEVEL]))
    else $error("User set did not take the security level.");
  user_unlock_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_UNLOCK
    && !sel_master && st_q.tries != '0 && pw_buf_q == user_pw_q
    |=> !st_q.locked && res_q == DSL_RES_DONE)
    else $error("Matching user password did not unlock.");
  erase_mode_a: assert property (go && !st_q.frozen && cmd == `DSL_CMD_ER_UNIT
    |=> erase_enh_q == $past(ctrl_q[`DSL_CW_ERMODE]))
    else $error("Erase mode bit not taken.");
  erase_miss_a: assert property (go && cmd == `DSL_CMD_ER_UNIT && !hit
    |=> res_q == DSL_RES_ABORT && !erase_q)
    else $error("Erase with a wrong password was accepted.");
  frozen_pw_a: assert property (go && st_q.frozen && cmd == `DSL_CMD_SET_PW
    |=> $stable(user_pw_q) && $stable(master_pw_q))
    else $error("Frozen device stored a password.");
endmodule

//--- rtl/dsl_map.svh
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH
// Register byte offsets.
`define DSL_OFS_CMD     8'h00
`define DSL_OFS_CTRL    8'h04
`define DSL_OFS_REV     8'h08
`define DSL_OFS_STAT    8'h0c
`define DSL_OFS_MREV    8'h10
`define DSL_OFS_PW_BASE 8'h20
`define DSL_OFS_PW_LAST 8'h3c
// Command codes.
`define DSL_CMD_SET_PW  8'hf1
`define DSL_CMD_UNLOCK  8'hf2
`define DSL_CMD_ER_PREP 8'hf3
`define DSL_CMD_ER_UNIT 8'hf4
`define DSL_CMD_FREEZE  8'hf5
`define DSL_CMD_DIS_PW  8'hf6
// Control word fields.
`define DSL_CW_IDENT    0
`define DSL_CW_ERMODE   1
`define DSL_CW_LEVEL    8
// Unlock attempt counter and password width.
`define DSL_TRY_INIT    3'h5
`define DSL_TRY_W       3
`define DSL_PW_BITS     256
`endif

//--- rtl/dsl_pkg.sv
package dsl_pkg;
  `include "dsl_map.svh"

  typedef enum logic [1:0] {
    DSL_RES_NONE  = 2'b00,
    DSL_RES_DONE  = 2'b01,
    DSL_RES_ABORT = 2'b10
  } dsl_res_t;

  typedef struct packed {
    logic                 locked;
    logic                 frozen;
    logic                 enabled;
    logic                 level_max;
    logic                 master_act;
    logic                 prep;
    logic [`DSL_TRY_W-1:0] tries;
  } dsl_state_t;
endpackage

//--- tb/dsl_host.sv
`timescale 1ns/1ps
module dsl_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Entered just after a rising edge; the wait is cut only by the bench timeout.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data no longer shows the last value.
    pwdata <= ~d;
    // One idle edge keeps a following call from driving the strobes twice in one step.
    @(posedge pclk);
  endtask

  // Words 1 to 16 of the block: the 32-byte password, eight bus words.
  task automatic send_pw(input logic [255:0] pw);
    logic [31:0] rd;
    logic        err;
    for (int n = 0; n < 8; n++)
      xfer(1'b1, 8'h20 + 8'(4 * n), pw[32*n +: 32], rd, err);
  endtask
endmodule

//--- tb/dsl_top_bench.sv
`timescale 1ns/1ps
`include "dsl_map.svh"
module dsl_top_bench;
  import dsl_pkg::*;
  localparam logic [255:0] PW_A = {8{32'ha5a5_0001}};
  localparam logic [255:0] PW_B = {8{32'h5a5a_0002}};
  localparam logic [255:0] PW_M = {8{32'h0f0f_0003}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        hw_rst_n = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, erase_start, erase_enhanced;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  int          starts = 0;

  always #5 pclk = ~pclk;

  dsl_top u_dsl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_rst_n(hw_rst_n), .erase_start(erase_start),
    .erase_enhanced(erase_enhanced));
  dsl_host u_dsl_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always @(posedge pclk)
  begin
    cycles++;
    if (erase_start === 1'b1)
      starts++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_dsl_host.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic stat(input logic [8:0] mask, input logic [8:0] exp);
    u_dsl_host.xfer(1'b0, `DSL_OFS_STAT, 32'h0, rd, err);
    check("status", {23'h0, rd[8:0] & mask}, {23'h0, exp});
  endtask

  task automatic cmd(input logic [7:0] code, input logic [15:0] cw, input logic [255:0] pw,
                     input dsl_res_t exp);
    wr(`DSL_OFS_CTRL, {16'h0000, cw});
    u_dsl_host.send_pw(pw);
    wr(`DSL_OFS_CMD, {24'h000000, code});
    u_dsl_host.xfer(1'b0, `DSL_OFS_CMD, 32'h0, rd, err);
    check("result", {30'h0, rd[9:8]}, {30'h0, exp});
  endtask

  // Hardware reset keeps passwords but relocks a device with a user password.
  task automatic hwrst();
    hw_rst_n <= 1'b0;
    repeat (3) @(posedge pclk);
    hw_rst_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_passwords();
    stat(9'h1ff, 9'h005);
    u_dsl_host.xfer(1'b0, 8'h44, 32'h0, rd, err);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(`DSL_OFS_REV, 32'h0000_00c3);
    cmd(`DSL_CMD_SET_PW, 16'h0001, PW_M, DSL_RES_DONE);
    u_dsl_host.xfer(1'b0, `DSL_OFS_MREV, 32'h0, rd, err);
    check("revision", rd, 32'h0000_00c3);
    stat(9'h1e0, 9'h000);
    wr(`DSL_OFS_REV, 32'h0000_005a);
    cmd(`DSL_CMD_SET_PW, 16'h0000, PW_A, DSL_RES_DONE);
    stat(9'h150, 9'h050);
    hwrst();
    stat(9'h1ff, 9'h155);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_B, DSL_RES_ABORT);
    stat(9'h007, 9'h004);
    cmd(`DSL_CMD_UNLOCK, 16'h0001, PW_M, DSL_RES_DONE);
    stat(9'h100, 9'h000);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_B, DSL_RES_ABORT);
    stat(9'h007, 9'h004);
    cmd(`DSL_CMD_DIS_PW, 16'h0000, PW_A, DSL_RES_DONE);
    stat(9'h150, 9'h000);
    u_dsl_host.xfer(1'b0, `DSL_OFS_MREV, 32'h0, rd, err);
    check("revision kept", rd, 32'h0000_00c3);
    cmd(`DSL_CMD_DIS_PW, 16'h0001, PW_M, DSL_RES_ABORT);
    cmd(`DSL_CMD_SET_PW, 16'h0000, PW_A, DSL_RES_DONE);
    hwrst();
    cmd(`DSL_CMD_UNLOCK, 16'h0001, PW_M, DSL_RES_DONE);
    $display("test passwords done");
  endtask

  task automatic t_maximum();
    cmd(`DSL_CMD_SET_PW, 16'h0100, PW_A, DSL_RES_DONE);
    stat(9'h060, 9'h060);
    hwrst();
    cmd(`DSL_CMD_UNLOCK, 16'h0001, PW_M, DSL_RES_ABORT);
    stat(9'h107, 9'h105);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_A, DSL_RES_DONE);
    stat(9'h100, 9'h000);
    $display("test maximum done");
  endtask

  task automatic t_erase();
    cmd(`DSL_CMD_ER_UNIT, 16'h0002, PW_A, DSL_RES_ABORT);
    cmd(`DSL_CMD_ER_PREP, 16'h0000, PW_A, DSL_RES_DONE);
    cmd(`DSL_CMD_ER_UNIT, 16'h0002, PW_B, DSL_RES_ABORT);
    check("erase count", 32'(starts), 32'h0);
    cmd(`DSL_CMD_ER_PREP, 16'h0000, PW_A, DSL_RES_DONE);
    cmd(`DSL_CMD_ER_UNIT, 16'h0002, PW_A, DSL_RES_DONE);
    check("erase count", 32'(starts), 32'h1);
    check("enhanced", {31'h0, erase_enhanced}, 32'h1);
    stat(9'h150, 9'h000);
    cmd(`DSL_CMD_SET_PW, 16'h0000, PW_A, DSL_RES_DONE);
    cmd(`DSL_CMD_ER_PREP, 16'h0000, PW_A, DSL_RES_DONE);
    cmd(`DSL_CMD_ER_UNIT, 16'h0000, PW_A, DSL_RES_DONE);
    check("enhanced", {31'h0, erase_enhanced}, 32'h0);
    $display("test erase done");
  endtask

  task automatic t_exhaust();
    cmd(`DSL_CMD_SET_PW, 16'h0000, PW_A, DSL_RES_DONE);
    hwrst();
    for (int i = 0; i < 5; i++)
      cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_B, DSL_RES_ABORT);
    stat(9'h107, 9'h100);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_A, DSL_RES_ABORT);
    cmd(`DSL_CMD_ER_PREP, 16'h0000, PW_A, DSL_RES_DONE);
    cmd(`DSL_CMD_ER_UNIT, 16'h0000, PW_A, DSL_RES_ABORT);
    hwrst();
    stat(9'h007, 9'h005);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_A, DSL_RES_DONE);
    $display("test exhaust done");
  endtask

  task automatic t_freeze();
    logic [7:0] codes [5] = '{`DSL_CMD_SET_PW, `DSL_CMD_UNLOCK, `DSL_CMD_ER_PREP,
                              `DSL_CMD_ER_UNIT, `DSL_CMD_DIS_PW};
    cmd(`DSL_CMD_FREEZE, 16'h0000, PW_A, DSL_RES_DONE);
    stat(9'h080, 9'h080);
    foreach (codes[i])
      cmd(codes[i], 16'h0000, PW_A, DSL_RES_ABORT);
    cmd(`DSL_CMD_SET_PW, 16'h0000, PW_B, DSL_RES_ABORT);
    cmd(`DSL_CMD_FREEZE, 16'h0000, PW_A, DSL_RES_DONE);
    stat(9'h080, 9'h080);
    hwrst();
    stat(9'h080, 9'h000);
    cmd(`DSL_CMD_UNLOCK, 16'h0000, PW_A, DSL_RES_DONE);
    $display("test freeze done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_passwords();
    t_maximum();
    t_erase();
    t_exhaust();
    t_freeze();
    summarize();
  end
endmodule
